// ==== hdl/sbc_burst_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbc_params.svh"

module sbc_burst_counter
    import sbc_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    load,
    input  wire logic                    advance,
    input  wire logic [`SBC_BURST_W-1:0] base_lo,
    input  wire logic                    interleave,
    output logic      [`SBC_BURST_W-1:0] burst_lo
);

    logic [`SBC_BURST_W-1:0] base;
    logic [`SBC_BURST_W-1:0] count;
    logic [`SBC_BURST_W-1:0] next_base;
    logic [`SBC_BURST_W-1:0] next_count;

    always_comb
    begin
        next_base  = base;
        next_count = count;
        if (load)
        begin
            next_base  = base_lo;
            next_count = `SBC_RST_BURST;
        end
        else if (advance)
        begin
            next_count = `SBC_BURST_W'(count + 2'h1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base  <= `SBC_RST_BURST;
            count <= `SBC_RST_BURST;
        end
        else
        begin
            base  <= next_base;
            count <= next_count;
        end
    end

    // only the two low bits move; the group of four wraps on itself
    assign burst_lo = interleave ? (base ^ count) : `SBC_BURST_W'(base + count);

endmodule

`default_nettype wire

// ==== hdl/sbc_control.sv ====
// Function
// - advance high steps the burst counter of an access in flight
// - advance low loads a fresh start address
// - edges count only with clock qualify low
// - qualify high freezes all state and data outputs; array enables drop low
// - select needs one low, two high, three low
// - output enable high forces pins to input
// - tristate on write data, deselect, first cycle
// - input pins captured into data register
// - read data drives one recognized clock later
// - output enable and control jointly set direction
// - each lane select gates byte and parity
// - static strap selects interleaved or linear order
`timescale 1ns/1ps
`default_nettype none
`include "sbc_params.svh"

module sbc_control
    import sbc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   clock_qualify_n,
    input  wire logic [`SBC_ADDR_W-1:0] address,
    input  wire logic                   advance_or_load_select,
    input  wire logic                   chip_select_one_n,
    input  wire logic                   chip_select_two,
    input  wire logic                   chip_select_three_n,
    input  wire logic                   write_enable_n,
    input  wire logic [`SBC_LANES-1:0]  byte_lane_select_n,
    input  wire logic                   output_enable_n,
    input  wire logic                   burst_order_strap,
    input  wire logic [`SBC_DATA_W-1:0] data_in,
    input  wire logic [`SBC_LANES-1:0]  parity_io_lines_in,
    output logic      [`SBC_DATA_W-1:0] data_out,
    output logic      [`SBC_LANES-1:0]  parity_io_lines_out,
    output logic                        data_oe,
    output logic                        mem_rd_en,
    output logic      [`SBC_ADDR_W-1:0] mem_rd_addr,
    input  wire logic [`SBC_WORD_W-1:0] mem_rd_data,
    output logic                        mem_wr_en,
    output logic      [`SBC_ADDR_W-1:0] mem_wr_addr,
    output logic      [`SBC_LANES-1:0]  mem_wr_lane_en,
    output logic      [`SBC_WORD_W-1:0] mem_wr_data
);

    // ----------------------------------------------------------------
    // reset and clock qualification
    // ----------------------------------------------------------------
    logic rst_n;
    logic ce;
    logic sel_now;
    logic load_req;

    sbc_reset_sync u_reset_sync
    (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_n  (rst_n)
    );

    assign ce       = ~clock_qualify_n;
    assign sel_now  = ~chip_select_one_n & chip_select_two & ~chip_select_three_n;
    assign load_req = ~advance_or_load_select;

    // ----------------------------------------------------------------
    // burst order strap, caught after reset release
    // ----------------------------------------------------------------
    logic strap_taken;
    logic interleave_mode;
    logic next_strap_taken;
    logic next_interleave_mode;

    always_comb
    begin
        next_strap_taken     = strap_taken;
        next_interleave_mode = interleave_mode;
        if (ce && !strap_taken)
        begin
            next_interleave_mode = burst_order_strap;
            next_strap_taken     = 1'b1;
        end
    end

    // strap is read once after each reset; a change in operation cannot disturb a burst
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_taken     <= `SBC_RST_FLAG;
            interleave_mode <= `SBC_RST_STRAP;
        end
        else
        begin
            strap_taken     <= next_strap_taken;
            interleave_mode <= next_interleave_mode;
        end
    end

    // ----------------------------------------------------------------
    // address stage
    // ----------------------------------------------------------------
    sbc_op_t                              s1_op;
    logic    [`SBC_ADDR_W-1:`SBC_BURST_W] s1_addr_hi;
    logic    [`SBC_LANES-1:0]             s1_lanes;
    logic                                 s1_fresh;
    sbc_op_t                              next_s1_op;
    logic    [`SBC_ADDR_W-1:`SBC_BURST_W] next_s1_addr_hi;
    logic    [`SBC_LANES-1:0]             next_s1_lanes;
    logic                                 next_s1_fresh;
    logic    [`SBC_BURST_W-1:0]           burst_lo;
    logic    [`SBC_ADDR_W-1:0]            s1_addr;
    logic                                 ctr_load;
    logic                                 ctr_advance;

    assign ctr_load    = ce & load_req & sel_now;
    // an advance with nothing in flight stays idle; the controller reloads
    assign ctr_advance = ce & advance_or_load_select & (s1_op != SBC_OP_IDLE);

    sbc_burst_counter u_burst_counter
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .load       (ctr_load),
        .advance    (ctr_advance),
        .base_lo    (address[`SBC_BURST_W-1:0]),
        .interleave (interleave_mode),
        .burst_lo   (burst_lo)
    );

    assign s1_addr = {s1_addr_hi, burst_lo};

    always_comb
    begin
        next_s1_op      = s1_op;
        next_s1_addr_hi = s1_addr_hi;
        next_s1_lanes   = s1_lanes;
        next_s1_fresh   = s1_fresh;
        if (ce)
        begin
            if (load_req)
            begin
                if (sel_now)
                begin
                    next_s1_op      = write_enable_n ? SBC_OP_READ : SBC_OP_WRITE;
                    next_s1_addr_hi = address[`SBC_ADDR_W-1:`SBC_BURST_W];
                    next_s1_lanes   = write_enable_n ? `SBC_RST_LANES : ~byte_lane_select_n;
                    next_s1_fresh   = (s1_op == SBC_OP_IDLE);
                end
                else
                begin
                    next_s1_op    = SBC_OP_IDLE;
                    next_s1_lanes = `SBC_RST_LANES;
                    next_s1_fresh = 1'b0;
                end
            end
            else
            begin
                // lane selects are taken fresh on every beat of a write burst
                next_s1_lanes = (s1_op == SBC_OP_WRITE) ? ~byte_lane_select_n : `SBC_RST_LANES;
                next_s1_fresh = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_op      <= SBC_OP_IDLE;
            s1_addr_hi <= (`SBC_ADDR_W-`SBC_BURST_W)'(`SBC_RST_ADDR >> `SBC_BURST_W);
            s1_lanes   <= `SBC_RST_LANES;
            s1_fresh   <= `SBC_RST_FLAG;
        end
        else
        begin
            s1_op      <= next_s1_op;
            s1_addr_hi <= next_s1_addr_hi;
            s1_lanes   <= next_s1_lanes;
            s1_fresh   <= next_s1_fresh;
        end
    end

    // ----------------------------------------------------------------
    // data stage
    // ----------------------------------------------------------------
    sbc_op_t                   s2_op;
    logic [`SBC_ADDR_W-1:0]    s2_addr;
    logic [`SBC_LANES-1:0]     s2_lanes;
    logic [`SBC_WORD_W-1:0]    rdata;
    logic [`SBC_WORD_W-1:0]    wdata;
    sbc_op_t                   next_s2_op;
    logic [`SBC_ADDR_W-1:0]    next_s2_addr;
    logic [`SBC_LANES-1:0]     next_s2_lanes;
    logic [`SBC_WORD_W-1:0]    next_rdata;
    logic [`SBC_WORD_W-1:0]    next_wdata;
    logic [`SBC_WORD_W-1:0]    pin_word;

    always_comb
    begin
        next_s2_op    = s2_op;
        next_s2_addr  = s2_addr;
        next_s2_lanes = s2_lanes;
        next_rdata    = rdata;
        if (ce)
        begin
            next_s2_op    = s1_op;
            next_s2_addr  = s1_addr;
            next_s2_lanes = s1_lanes;
            if (s1_op == SBC_OP_READ)
            begin
                next_rdata = mem_rd_data;
            end
        end
    end

    genvar lane;
    generate
        for (lane = 0; lane < `SBC_LANES; lane = lane + 1)
        begin : g_lane
            assign pin_word[lane*`SBC_LANE_W +: `SBC_LANE_W] =
                {parity_io_lines_in[lane], data_in[lane*`SBC_BYTE_W +: `SBC_BYTE_W]};
            // pins are sampled only while they act as inputs
            assign next_wdata[lane*`SBC_LANE_W +: `SBC_LANE_W] = (ce && !data_oe) ?
                pin_word[lane*`SBC_LANE_W +: `SBC_LANE_W] : wdata[lane*`SBC_LANE_W +: `SBC_LANE_W];
            assign data_out[lane*`SBC_BYTE_W +: `SBC_BYTE_W] = rdata[lane*`SBC_LANE_W +: `SBC_BYTE_W];
            assign parity_io_lines_out[lane] = rdata[lane*`SBC_LANE_W + `SBC_PARITY_POS];
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s2_op    <= SBC_OP_IDLE;
            s2_addr  <= `SBC_RST_ADDR;
            s2_lanes <= `SBC_RST_LANES;
            rdata    <= `SBC_RST_WORD;
            wdata    <= `SBC_RST_WORD;
        end
        else
        begin
            s2_op    <= next_s2_op;
            s2_addr  <= next_s2_addr;
            s2_lanes <= next_s2_lanes;
            rdata    <= next_rdata;
            wdata    <= next_wdata;
        end
    end

    // ----------------------------------------------------------------
    // pin direction and array port
    // ----------------------------------------------------------------
    logic drive_ok;

    // a read in flight is cut off if write data or a fresh select owns the bus
    assign drive_ok = (s2_op == SBC_OP_READ) & (s1_op != SBC_OP_WRITE) & ~s1_fresh;
    assign data_oe  = ~output_enable_n & drive_ok;

    // array read is combinational; a stretched cycle issues no extra access
    assign mem_rd_en      = ce & (s1_op == SBC_OP_READ);
    assign mem_rd_addr    = s1_addr;
    assign mem_wr_en      = ce & (s2_op == SBC_OP_WRITE) & (|s2_lanes);
    assign mem_wr_addr    = s2_addr;
    assign mem_wr_lane_en = s2_lanes;
    assign mem_wr_data    = wdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // checks wait one edge past release; at the release edge the flops still sit in reset
    logic chk_en;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_en <= 1'b0;
        end
        else
        begin
            chk_en <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!chk_en);

    a_freeze_all_state: assert property (!ce |=> $stable(s1_op) && $stable(s1_addr) && $stable(s2_op)
        && $stable(data_out) && $stable(wdata)) else $error("state moved while clock not qualified");
    a_load_new_addr: assert property (ce && load_req && sel_now |=> s1_addr == $past(address))
        else $error("loaded address not captured");
    a_advance_burst_step: assert property (ctr_advance |=> s1_addr_hi == $past(s1_addr_hi)
        && s1_addr[0] != $past(s1_addr[0]) && s1_op == $past(s1_op)) else $error("advance did not step");
    a_linear_wrap_order: assert property (ctr_advance && !interleave_mode
        |=> s1_addr[1:0] == 2'($past(s1_addr[1:0]) + 2'h1)) else $error("linear order broken");
    a_idle_advance_stays: assert property (ce && advance_or_load_select && s1_op == SBC_OP_IDLE
        |=> s1_op == SBC_OP_IDLE) else $error("advance from idle started access");
    a_select_decode_off: assert property (ce && load_req && !sel_now |=> s1_op == SBC_OP_IDLE)
        else $error("access without full select");
    a_write_enable_sample: assert property (ce && load_req && sel_now
        |=> s1_op == ($past(write_enable_n) ? SBC_OP_READ : SBC_OP_WRITE)) else $error("wrong access kind");
    a_oe_high_input: assert property (output_enable_n |-> !data_oe)
        else $error("driving with output enable high");
    a_internal_mask: assert property (s1_op == SBC_OP_WRITE || s2_op != SBC_OP_READ || s1_fresh |-> !data_oe)
        else $error("drivers on in masked cycle");
    a_joint_direction: assert property (data_oe |-> !output_enable_n && s2_op == SBC_OP_READ)
        else $error("drivers on without both controls");
    a_input_capture: assert property (ce && !data_oe |=> wdata == $past(pin_word))
        else $error("input pins not captured");
    a_read_one_clock: assert property (ce && s1_op == SBC_OP_READ |=> rdata == $past(mem_rd_data)
        && s2_op == SBC_OP_READ) else $error("read data late or wrong");
    // a frozen edge between address and data stage leaves the lanes where they were
    a_lane_select_gate: assert property (ce && load_req && sel_now && !write_enable_n
        |=> s1_lanes == ~$past(byte_lane_select_n) ##1 (!$past(ce) || mem_wr_lane_en == $past(s1_lanes)))
        else $error("lane enables not carried");
    a_strap_static: assert property (strap_taken |=> $stable(interleave_mode))
        else $error("burst order changed");

    c_read_burst: cover property (ce && load_req && sel_now && write_enable_n ##1 ctr_advance [*3]);
    c_write_then_read: cover property (s1_op == SBC_OP_WRITE ##1 s1_op == SBC_OP_READ ##1 data_oe);
    c_freeze_in_read: cover property (data_oe && !ce ##1 data_oe);
    c_deselect_reload: cover property (s1_op == SBC_OP_IDLE ##1 s1_fresh);

endmodule

`default_nettype wire

// ==== hdl/sbc_params.svh ====
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SBC_ADDR_W      21
`define SBC_BURST_W     2
`define SBC_LANES       4
`define SBC_BYTE_W      8
`define SBC_LANE_W      9
`define SBC_DATA_W      32
`define SBC_WORD_W      36
`define SBC_PARITY_POS  8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SBC_RST_ADDR    21'h000000
`define SBC_RST_BURST   2'h0
`define SBC_RST_LANES   4'h0
`define SBC_RST_WORD    36'h000000000
`define SBC_RST_STRAP   1'b1
`define SBC_RST_FLAG    1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBC_READ_LATENCY 1

`endif

// ==== hdl/sbc_pkg.sv ====
package sbc_pkg;

    // ----------------------------------------------------------------
    // access kind held in each pipeline stage
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SBC_OP_IDLE  = 2'b00,
        SBC_OP_READ  = 2'b01,
        SBC_OP_WRITE = 2'b10
    } sbc_op_t;

endpackage

// ==== hdl/sbc_reset_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module sbc_reset_sync
(
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      rst_n
);

    logic meta;

    // two stages; the first is read only by the second
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta  <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            meta  <= 1'b1;
            rst_n <= meta;
        end
    end

endmodule

`default_nettype wire

// ==== verification/sbc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbc_params.svh"

// ----------------------------------------------------------------
// array behind the control block, asynchronous read
// ----------------------------------------------------------------
module sbc_mem_model
(
    input  wire logic                   clk,
    input  wire logic                   rd_en,
    input  wire logic [`SBC_ADDR_W-1:0] rd_addr,
    output logic      [`SBC_WORD_W-1:0] rd_data,
    input  wire logic                   wr_en,
    input  wire logic [`SBC_ADDR_W-1:0] wr_addr,
    input  wire logic [`SBC_LANES-1:0]  wr_lane_en,
    input  wire logic [`SBC_WORD_W-1:0] wr_data
);
    logic [`SBC_WORD_W-1:0] mem [0:63];
    logic [`SBC_WORD_W-1:0] junk;

    initial
    begin
        junk = 36'h0;
        for (int i = 0; i < 64; i++)
            mem[i] = 36'h0;
    end

    // unread cycles show a word that flips each cycle, so stale data never passes
    assign rd_data = rd_en ? mem[rd_addr[5:0]] : junk;

    always @(posedge clk)
    begin
        junk <= ~rd_data;
        if (wr_en)
            for (int i = 0; i < `SBC_LANES; i++)
                if (wr_lane_en[i])
                    mem[wr_addr[5:0]][i*`SBC_LANE_W +: `SBC_LANE_W] <= wr_data[i*`SBC_LANE_W +: `SBC_LANE_W];
    end
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import sbc_pkg::*;
;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] DES = 3'h6;

    logic        clk, arst_n, q_n, adv, cs1_n, cs2, cs3_n, we_n, oe_n, strap, host_en, oe_req;
    logic [20:0] addr;
    logic [3:0]  lanes_n, lanes_req;
    logic [35:0] host_word;
    logic [31:0] pin_d, data_out;
    logic [3:0]  pin_p, par_out, wr_lane_en;
    logic        data_oe, rd_en, wr_en;
    logic [20:0] rd_addr, wr_addr;
    logic [35:0] rd_data, wr_data;
    logic [35:0] shadow [0:63];
    int          fail_count, checked, cycles;

    // ----------------------------------------------------------------
    // pin level: device drives when enabled, else host, else a flipped word
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [8:0] drv;
        drv = 9'h0;
        for (int i = 0; i < 4; i++)
        begin
            drv = data_oe ? {par_out[i], data_out[8*i +: 8]} : host_en ? host_word[9*i +: 9] : ~host_word[9*i +: 9];
            pin_d[8*i +: 8] = drv[7:0];
            pin_p[i] = drv[8];
        end
    end

    sbc_control dut
    (
        .clk(clk), .arst_n(arst_n), .clock_qualify_n(q_n), .address(addr), .advance_or_load_select(adv),
        .chip_select_one_n(cs1_n), .chip_select_two(cs2), .chip_select_three_n(cs3_n), .write_enable_n(we_n),
        .byte_lane_select_n(lanes_n), .output_enable_n(oe_n), .burst_order_strap(strap), .data_in(pin_d),
        .parity_io_lines_in(pin_p), .data_out(data_out), .parity_io_lines_out(par_out), .data_oe(data_oe),
        .mem_rd_en(rd_en), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data), .mem_wr_en(wr_en),
        .mem_wr_addr(wr_addr), .mem_wr_lane_en(wr_lane_en), .mem_wr_data(wr_data)
    );

    sbc_mem_model mem
    (
        .clk(clk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_lane_en(wr_lane_en), .wr_data(wr_data)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [35:0] seen_v, input logic [35:0] exp);
        checked++;
        if (seen_v !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen_v);
        end
    endtask

    function automatic logic [35:0] seen();
        for (int i = 0; i < 4; i++)
            seen[9*i +: 9] = {par_out[i], data_out[8*i +: 8]};
    endfunction

    function automatic logic [20:0] baddr(input logic [20:0] b, input int k, input logic ilv);
        baddr = {b[20:2], ilv ? b[1:0] ^ k[1:0] : b[1:0] + k[1:0]};
    endfunction

    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] ln);
        for (int i = 0; i < 4; i++)
            if (!ln[i])
                old[9*i +: 9] = nw[9*i +: 9];
        return old;
    endfunction

    // one controller cycle; outputs seen on return reflect the previous request
    task automatic op(input logic a, input logic [2:0] cs, input logic w, input logic [20:0] ad,
                      input logic [35:0] hw, input logic he);
        @(posedge clk);
        q_n <= 1'h0;
        adv <= a;
        {cs1_n, cs2, cs3_n} <= cs;
        we_n <= w;
        addr <= ad;
        host_word <= hw;
        host_en <= he;
        oe_n <= oe_req;
        lanes_n <= lanes_req;
        #1;
    endtask

    task automatic idle();
        op(1'h0, DES, 1'h1, 21'h0, 36'h0, 1'h0);
    endtask

    task automatic do_reset(input logic s);
        strap <= s;
        arst_n <= 1'h0;
        repeat (4) idle();
        arst_n <= 1'h1;
        repeat (3) idle();
    endtask

    task automatic stall(input int n);
        logic [35:0] w;
        logic        oe;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            q_n <= 1'h1;
            we_n <= 1'h0;
            adv <= ~adv;
            #1;
            if (i == 0)
                w = seen();
            if (i == 0)
                oe = data_oe;
            check("stalled word", seen(), w);
            check("stalled oe", 36'(data_oe), 36'(oe));
            check("stalled write", 36'(wr_en), 36'h0);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic write_burst(input logic [20:0] b, input logic ilv, input logic [35:0] d);
        logic [20:0] a;
        op(1'h0, SEL, 1'h0, b, 36'h0, 1'h0);
        for (int k = 0; k < 4; k++)
        begin
            op(k < 3, k < 3 ? SEL : DES, k == 3, 21'h0, d + 36'(k), 1'h1);
            a = baddr(b, k, ilv);
            shadow[a[5:0]] = merge(shadow[a[5:0]], d + 36'(k), lanes_req);
            check("oe in write", 36'(data_oe), 36'h0);
        end
        idle();
        check("oe after write", 36'(data_oe), 36'h0);
    endtask

    task automatic read_one(input logic [20:0] ad, input logic [2:0] cs, input logic off);
        oe_req = off;
        op(1'h0, cs, 1'h1, ad, 36'h0, 1'h0);
        idle();
        check("oe first cycle", 36'(data_oe), 36'h0);
        check("array read", 36'(rd_en), 36'(cs == SEL));
        idle();
        check("oe on read", 36'(data_oe), 36'(cs == SEL && !off));
        if (cs == SEL)
            check("read word", seen(), shadow[ad[5:0]]);
        idle();
        check("oe deselected", 36'(data_oe), 36'h0);
        oe_req = 1'h0;
    endtask

    task automatic read_burst(input logic [20:0] b, input logic ilv);
        logic [20:0] a;
        op(1'h0, SEL, 1'h1, b, 36'h0, 1'h0);
        for (int j = 1; j < 7; j++)
        begin
            op(j < 4, j < 4 ? SEL : DES, 1'h1, 21'h0, 36'h0, 1'h0);
            a = baddr(b, (j + 2) % 4, ilv);
            if (j >= 2 && j <= 5)
                check("burst word", seen(), shadow[a[5:0]]);
            check("burst oe", 36'(data_oe), 36'(j >= 2 && j <= 5));
            if (j == 3)
                stall(3);
        end
    endtask

    // read and write back to back with no dead cycle between them
    task automatic turn_around(input logic [20:0] ra, input logic [20:0] wb, input logic [20:0] wc);
        op(1'h0, SEL, 1'h1, ra, 36'h0, 1'h0);
        op(1'h0, SEL, 1'h0, wb, 36'h0, 1'h0);
        op(1'h0, DES, 1'h1, 21'h0, 36'h5_5AA5_A55A, 1'h1);
        shadow[wb[5:0]] = merge(shadow[wb[5:0]], 36'h5_5AA5_A55A, lanes_req);
        check("read before write", seen(), shadow[ra[5:0]]);
        check("oe write data", 36'(data_oe), 36'h0);
        op(1'h0, SEL, 1'h0, wc, 36'h0, 1'h0);
        op(1'h0, SEL, 1'h1, ra, 36'h3_C33C_3CC3, 1'h1);
        shadow[wc[5:0]] = merge(shadow[wc[5:0]], 36'h3_C33C_3CC3, lanes_req);
        idle();
        idle();
        check("read after write", seen(), shadow[ra[5:0]]);
        check("oe after write", 36'(data_oe), 36'h1);
        idle();
        read_one(wb, SEL, 1'h0);
        read_one(wc, SEL, 1'h0);
        // advance after deselect must not start an access
        op(1'h1, SEL, 1'h1, 21'h0, 36'h0, 1'h0);
        idle();
        check("advance idle read", 36'(rd_en), 36'h0);
        idle();
        check("advance idle oe", 36'(data_oe), 36'h0);
    endtask

    // ----------------------------------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            close_out();
        end
    end

    initial
    begin
        {arst_n, q_n, adv, cs1_n, cs2, cs3_n, we_n, oe_n, strap, host_en, oe_req} = 11'h0C4;
        addr = 21'h0;
        lanes_n = 4'h0;
        lanes_req = 4'h0;
        host_word = 36'h0;
        for (int i = 0; i < 64; i++)
            shadow[i] = 36'h0;
        do_reset(1'h0);
        write_burst(21'h000011, 1'h0, 36'h1_2345_6780);
        for (int k = 0; k < 4; k++)
            read_one(21'h000010 | 21'(k), SEL, 1'h0);
        read_burst(21'h000013, 1'h0);
        for (int c = 0; c < 8; c++)
            read_one(21'h000012, c[2:0], 1'h0);
        read_one(21'h000012, SEL, 1'h1);
        lanes_req = 4'hA;
        write_burst(21'h000010, 1'h0, 36'hF_0F0F_0F00);
        read_burst(21'h000010, 1'h0);
        lanes_req = 4'h0;
        turn_around(21'h000011, 21'h000020, 21'h000021);
        do_reset(1'h1);
        write_burst(21'h000031, 1'h1, 36'h8_7654_3210);
        for (int k = 0; k < 4; k++)
            read_one(21'h000030 | 21'(k), SEL, 1'h0);
        read_burst(21'h000032, 1'h1);
        close_out();
    end
endmodule

`default_nettype wire
